// ---- card_clock_divider.sv ----
`timescale 1ns/1ps
module card_clock_divider (
    input wire logic clk_i,
    input wire logic rstn_i,
    clk_div_if.gen dv
);
    import sd_clk_pkg::*;

    logic [9:0] div_q;
    logic byp_q;
    logic edge_q;
    logic run_q;
    logic [10:0] cnt_q;
    logic [10:0] last;
    logic [10:0] half;
    logic wrap;
    logic level_q;
    logic level_dly_q;
    logic src_clk;

    assign last = {1'b0, div_q} + 11'h001;
    assign half = 11'(({1'b0, div_q} + 11'h002) >> 1);
    assign wrap = run_q && (byp_q || cnt_q == last);

    // Settings are taken only while stopped or at a period end
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            div_q <= '0;
            byp_q <= 1'b0;
            edge_q <= 1'b0;
            run_q <= 1'b0;
            cnt_q <= '0;
        end else if (!run_q || wrap) begin
            div_q <= dv.divisor;
            byp_q <= dv.bypass;
            edge_q <= dv.edge_sel;
            run_q <= dv.run;
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_q + 11'h001;
        end
    end

    // High for the first half of each divisor+2 period
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            level_q <= 1'b0;
            level_dly_q <= 1'b0;
        end else begin
            level_q <= run_q && !byp_q && (cnt_q < half);
            level_dly_q <= level_q;
        end
    end

    // Single clock: falling-edge choice becomes inverted source in bypass
    // and a one-cycle retime when dividing
    assign src_clk = edge_q ? ~clk_i : clk_i;
    assign dv.card_clk = byp_q ? (src_clk & run_q)
                               : (edge_q ? level_dly_q : level_q);
    assign dv.boundary = wrap;
    assign dv.running = run_q;

    a_stop_low: assert property (@(posedge clk_i) disable iff (!rstn_i)
        !run_q && !$past(run_q) && !byp_q |-> !dv.card_clk)
        else $error("card clock not low while stopped");
    a_cfg_boundary: assert property (@(posedge clk_i) disable iff (!rstn_i)
        !$stable(div_q) |-> $past(!run_q || wrap))
        else $error("divisor changed inside a period");
    a_period_len: assert property (@(posedge clk_i) disable iff (!rstn_i)
        run_q && !byp_q && cnt_q == 11'h000 && div_q == 10'h002
        |-> ##3 wrap)
        else $error("divided period length wrong");
endmodule : card_clock_divider

// ---- clk_div_if.sv ----
`timescale 1ns/1ps
interface clk_div_if;
    logic [9:0] divisor;
    logic bypass;
    logic edge_sel;
    logic run;
    logic card_clk;
    logic boundary;
    logic running;
    modport ctrl (output divisor, bypass, edge_sel, run,
                  input card_clk, boundary, running);
    modport gen (input divisor, bypass, edge_sel, run,
                 output card_clk, boundary, running);
endinterface : clk_div_if

// ---- sd_card_clock_ctrl.sv ----
`timescale 1ns/1ps
// Functional notes
// - Power field 00 stops card clock, 11 starts it; 01 and 10 reserved.
// - Card clock equals kernel clock divided by ten-bit divisor plus two.
// - Flow control bit gives buffer flags their flow-control meaning.
// - Edge bit picks rising or falling kernel edge as source; falling only in bypass, divided clock is delayed one kernel cycle.
// - Width field selects one, four or eight data lines.
// - Bypass drives card clock straight from kernel clock, ignoring divisor.
// - Idle gating outputs the card clock only while bus is active.
// - Output enable low means no card clock is driven.
// - Data path may stop the card clock during read wait.
// - Clock halts two periods after block end bit, restarts on end.
// - Flow control prevents buffer under/overflow; buffer access stays open.
module sd_card_clock_ctrl (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic reg_sel_i,
    input wire logic reg_write_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    output logic [31:0] reg_rdata_o,
    output logic reg_error_o,
    input wire logic bus_active_i,
    input wire logic read_wait_clock_stop_i,
    input wire logic block_end_i,
    input wire logic read_wait_end_i,
    input wire logic transmit_buffer_empty_flag_i,
    input wire logic receive_buffer_full_flag_i,
    output logic card_clock_pin_o,
    output logic card_power_on_o,
    output logic [1:0] data_lane_width_o,
    output logic [7:0] data_lane_enable_o,
    output logic buffer_flow_throttle_enable_o,
    output logic tx_empty_flow_o,
    output logic rx_full_flow_o
);
    import sd_clk_pkg::*;

    clk_div_if dv ();

    logic [1:0] card_power_state_q;
    logic [9:0] card_clock_divisor_q;
    logic buffer_flow_throttle_enable_q;
    logic source_edge_select_q;
    logic [1:0] data_lane_width_q;
    logic divider_bypass_q;
    logic idle_clock_gating_q;
    logic card_clock_output_enable_q;
    logic [7:0] lane_enable_q;
    rw_state_type rw_state_q;
    logic [1:0] rw_cnt_q;
    logic hit_pwr;
    logic hit_clk;
    logic mapped;
    logic flow_hold;
    logic run_d;
    logic [31:0] clk_word;
    logic [10:0] pwr_wait_q;
    logic [10:0] oe_wait_q;
    logic [10:0] rw_wait_q;

    assign hit_pwr = reg_addr_i == PWR_OFFSET;
    assign hit_clk = reg_addr_i == CLK_OFFSET;
    assign mapped = hit_pwr || hit_clk;

    // Write spacing is the software's job; back-to-back writes still land
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            card_power_state_q <= PWR_RESET[PS_LSB +: 2];
        end else if (reg_sel_i && reg_write_i && hit_pwr) begin
            card_power_state_q <= reg_wdata_i[PS_LSB +: 2];
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            card_clock_divisor_q <= {CLK_RESET[DIV_HI_LSB +: DIV_HI_W],
                                     CLK_RESET[DIV_LO_LSB +: DIV_LO_W]};
            buffer_flow_throttle_enable_q <= CLK_RESET[HFC_BIT];
            source_edge_select_q <= CLK_RESET[EDGE_BIT];
            data_lane_width_q <= CLK_RESET[WIDTH_LSB +: 2];
            divider_bypass_q <= CLK_RESET[BYP_BIT];
            idle_clock_gating_q <= CLK_RESET[IDLE_BIT];
            card_clock_output_enable_q <= CLK_RESET[OE_BIT];
        end else if (reg_sel_i && reg_write_i && hit_clk) begin
            card_clock_divisor_q <= {reg_wdata_i[DIV_HI_LSB +: DIV_HI_W],
                                     reg_wdata_i[DIV_LO_LSB +: DIV_LO_W]};
            buffer_flow_throttle_enable_q <= reg_wdata_i[HFC_BIT];
            source_edge_select_q <= reg_wdata_i[EDGE_BIT];
            data_lane_width_q <= reg_wdata_i[WIDTH_LSB +: 2];
            divider_bypass_q <= reg_wdata_i[BYP_BIT];
            idle_clock_gating_q <= reg_wdata_i[IDLE_BIT];
            card_clock_output_enable_q <= reg_wdata_i[OE_BIT];
        end
    end

    always_comb begin
        clk_word = '0;
        clk_word[DIV_HI_LSB +: DIV_HI_W] = card_clock_divisor_q[9:8];
        clk_word[DIV_LO_LSB +: DIV_LO_W] = card_clock_divisor_q[7:0];
        clk_word[HFC_BIT] = buffer_flow_throttle_enable_q;
        clk_word[EDGE_BIT] = source_edge_select_q;
        clk_word[WIDTH_LSB +: 2] = data_lane_width_q;
        clk_word[BYP_BIT] = divider_bypass_q;
        clk_word[IDLE_BIT] = idle_clock_gating_q;
        clk_word[OE_BIT] = card_clock_output_enable_q;
    end

    // Read data and error answer one cycle after the select
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            reg_rdata_o <= '0;
            reg_error_o <= 1'b0;
        end else begin
            reg_error_o <= reg_sel_i && !mapped;
            if (reg_sel_i && !reg_write_i) begin
                if (hit_pwr) begin
                    reg_rdata_o <= {30'h0, card_power_state_q};
                end else if (hit_clk) begin
                    reg_rdata_o <= clk_word;
                end else begin
                    reg_rdata_o <= '0;
                end
            end
        end
    end

    // Reserved width code falls back to a single lane
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            lane_enable_q <= LANES_ONE;
        end else begin
            case (data_lane_width_q)
                WIDTH_ONE: lane_enable_q <= LANES_ONE;
                WIDTH_FOUR: lane_enable_q <= LANES_FOUR;
                WIDTH_EIGHT: lane_enable_q <= LANES_EIGHT;
                default: lane_enable_q <= LANES_ONE;
            endcase
        end
    end

    // Clock-stop read wait sequencer
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rw_state_q <= RW_RUN;
            rw_cnt_q <= '0;
        end else begin
            case (rw_state_q)
                RW_RUN: begin
                    rw_cnt_q <= '0;
                    if (read_wait_clock_stop_i && block_end_i) begin
                        rw_state_q <= RW_COUNT;
                    end
                end
                RW_COUNT: begin
                    if (read_wait_end_i) begin
                        rw_state_q <= RW_RUN;
                    end else if (dv.boundary || !dv.running) begin
                        rw_cnt_q <= rw_cnt_q + 2'h1;
                        if (rw_cnt_q == RW_STOP_PERIODS - 2'h1) begin
                            rw_state_q <= RW_STOPPED;
                        end
                    end
                end
                RW_STOPPED: begin
                    if (read_wait_end_i) begin
                        rw_state_q <= RW_RUN;
                    end
                end
                default: rw_state_q <= RW_RUN;
            endcase
        end
    end

    // Flow control pauses the card, never the buffer port
    assign flow_hold = buffer_flow_throttle_enable_q &&
        (transmit_buffer_empty_flag_i || receive_buffer_full_flag_i);

    assign run_d = (card_power_state_q == PS_ON) &&
        card_clock_output_enable_q &&
        (!idle_clock_gating_q || bus_active_i) &&
        (rw_state_q != RW_STOPPED) &&
        !flow_hold;

    assign dv.divisor = card_clock_divisor_q;
    assign dv.bypass = divider_bypass_q;
    assign dv.edge_sel = source_edge_select_q;
    assign dv.run = run_d;

    card_clock_divider u_div (
        .clk_i (clk_i),
        .rstn_i (rstn_i),
        .dv (dv)
    );

    assign card_clock_pin_o = dv.card_clk;
    assign card_power_on_o = card_power_state_q == PS_ON;
    assign data_lane_width_o = data_lane_width_q;
    assign data_lane_enable_o = lane_enable_q;
    assign buffer_flow_throttle_enable_o = buffer_flow_throttle_enable_q;
    assign tx_empty_flow_o = buffer_flow_throttle_enable_q &&
        transmit_buffer_empty_flag_i;
    assign rx_full_flow_o = buffer_flow_throttle_enable_q &&
        receive_buffer_full_flag_i;

    // Stop watchdogs: a stop may wait out one full period, never more
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pwr_wait_q <= '0;
            oe_wait_q <= '0;
            rw_wait_q <= '0;
        end else begin
            pwr_wait_q <= (card_power_state_q != PS_ON && dv.running) ?
                pwr_wait_q + 11'h001 : 11'h000;
            oe_wait_q <= (!card_clock_output_enable_q && dv.running) ?
                oe_wait_q + 11'h001 : 11'h000;
            rw_wait_q <= (rw_state_q == RW_STOPPED && dv.running) ?
                rw_wait_q + 11'h001 : 11'h000;
        end
    end

    a_power_off_stop: assert property (@(posedge clk_i) disable iff (!rstn_i)
        !(pwr_wait_q > STOP_WAIT_MAX))
        else $error("clock still running with power off");
    a_power_on_start: assert property (@(posedge clk_i) disable iff (!rstn_i)
        $rose(card_power_on_o) && card_clock_output_enable_q &&
        !idle_clock_gating_q && !flow_hold && rw_state_q == RW_RUN
        && !dv.running |=> dv.running)
        else $error("clock not started at power on");
    a_oe_gate: assert property (@(posedge clk_i) disable iff (!rstn_i)
        !(oe_wait_q > STOP_WAIT_MAX))
        else $error("clock driven with output disabled");
    a_idle_gate: assert property (@(posedge clk_i) disable iff (!rstn_i)
        idle_clock_gating_q && !bus_active_i && !dv.running
        |=> !dv.running || bus_active_i || !idle_clock_gating_q)
        else $error("gated clock started while bus idle");
    a_lane_mask: assert property (@(posedge clk_i) disable iff (!rstn_i)
        data_lane_width_q == WIDTH_FOUR && $past(data_lane_width_q) ==
        WIDTH_FOUR |-> data_lane_enable_o == LANES_FOUR)
        else $error("lane mask wrong for four lines");
    a_rw_restart: assert property (@(posedge clk_i) disable iff (!rstn_i)
        rw_state_q == RW_STOPPED && read_wait_end_i
        |=> rw_state_q == RW_RUN)
        else $error("read wait did not end");
    a_rw_stop: assert property (@(posedge clk_i) disable iff (!rstn_i)
        !(rw_wait_q > STOP_WAIT_MAX))
        else $error("clock not stopped in read wait");
    a_flow_pause: assert property (@(posedge clk_i) disable iff (!rstn_i)
        flow_hold && !dv.running |=> !dv.running)
        else $error("flow hold did not stop clock request");
    a_bad_addr: assert property (@(posedge clk_i) disable iff (!rstn_i)
        reg_sel_i && !mapped |=> reg_error_o)
        else $error("unmapped access not flagged");

    c_bypass_run: cover property (@(posedge clk_i) disable iff (!rstn_i)
        divider_bypass_q && dv.running);
    c_rw_stopped: cover property (@(posedge clk_i) disable iff (!rstn_i)
        rw_state_q == RW_STOPPED ##1 rw_state_q == RW_RUN);
    c_four_lanes: cover property (@(posedge clk_i) disable iff (!rstn_i)
        data_lane_enable_o == LANES_FOUR && dv.running);
    c_flow_hold: cover property (@(posedge clk_i) disable iff (!rstn_i)
        flow_hold ##1 !flow_hold);
endmodule : sd_card_clock_ctrl

// ---- sd_card_model.sv ----
`timescale 1ns/1ps
module sd_card_model (
    input wire logic card_clk_i,
    output int edges_o,
    output int period_ns_o
);
    realtime last_t;

    initial begin
        edges_o = 0;
        period_ns_o = 0;
        last_t = 0.0;
    end

    // Period in ns between rising edges, the card only sees edges
    always @(posedge card_clk_i) begin
        period_ns_o = int'($realtime - last_t);
        last_t = $realtime;
        edges_o = edges_o + 1;
    end
endmodule : sd_card_model

// ---- sd_clk_pkg.sv ----
package sd_clk_pkg;
    localparam logic [7:0] PWR_OFFSET = 8'h00;
    localparam logic [7:0] CLK_OFFSET = 8'h04;
    localparam logic [1:0] ADDR_ALIGN = 2'h0;
    localparam logic [31:0] PWR_RESET = 32'h0000_0000;
    localparam logic [31:0] CLK_RESET = 32'h0000_0000;
    localparam int PS_LSB = 0;
    localparam int DIV_LO_LSB = 0;
    localparam int DIV_LO_W = 8;
    localparam int OE_BIT = 8;
    localparam int IDLE_BIT = 9;
    localparam int BYP_BIT = 10;
    localparam int WIDTH_LSB = 11;
    localparam int EDGE_BIT = 13;
    localparam int HFC_BIT = 14;
    localparam int DIV_HI_LSB = 15;
    localparam int DIV_HI_W = 2;
    localparam int DIV_W = 10;
    localparam logic [1:0] PS_OFF = 2'h0;
    localparam logic [1:0] PS_ON = 2'h3;
    localparam logic [1:0] WIDTH_ONE = 2'h0;
    localparam logic [1:0] WIDTH_FOUR = 2'h1;
    localparam logic [1:0] WIDTH_EIGHT = 2'h2;
    localparam logic [7:0] LANES_ONE = 8'h01;
    localparam logic [7:0] LANES_FOUR = 8'h0f;
    localparam logic [7:0] LANES_EIGHT = 8'hff;
    localparam logic [1:0] RW_STOP_PERIODS = 2'h2;
    localparam logic [10:0] STOP_WAIT_MAX = 11'h401;
    typedef enum logic [1:0] {
        RW_RUN = 2'b00,
        RW_COUNT = 2'b01,
        RW_STOPPED = 2'b10
    } rw_state_type;
endpackage : sd_clk_pkg

// ---- tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
    import sd_clk_pkg::*;
    logic clk_i, rstn_i, sel, wr_en, bus_act, rw_stop, blk_end, rw_end;
    logic tx_f, rx_f, pin, pwr_on, hfc, tx_fl, rx_fl, err;
    logic [7:0] addr, lanes;
    logic [31:0] wdata, rdata;
    logic [1:0] width;
    int edges, period, errors, n_checks;
    logic [9:0] divs [5] = '{10'h3ff, 10'h102, 10'h001, 10'h002, 10'h000};
    logic [7:0] lane_exp [4] = '{LANES_ONE, LANES_FOUR, LANES_EIGHT, LANES_ONE};

    sd_card_clock_ctrl i_dut (.clk_i(clk_i), .rstn_i(rstn_i),
        .reg_sel_i(sel), .reg_write_i(wr_en), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_error_o(err),
        .bus_active_i(bus_act), .read_wait_clock_stop_i(rw_stop),
        .block_end_i(blk_end), .read_wait_end_i(rw_end),
        .transmit_buffer_empty_flag_i(tx_f),
        .receive_buffer_full_flag_i(rx_f), .card_clock_pin_o(pin),
        .card_power_on_o(pwr_on), .data_lane_width_o(width),
        .data_lane_enable_o(lanes), .buffer_flow_throttle_enable_o(hfc),
        .tx_empty_flow_o(tx_fl), .rx_full_flow_o(rx_fl));
    sd_card_model i_card (.card_clk_i(pin), .edges_o(edges),
        .period_ns_o(period));

    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    task automatic wrap_up;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : wrap_up

    task automatic chk(input string nm, input logic [31:0] e, g);
        n_checks++;
        if (g !== e) begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", nm, e, g);
        end
    endtask : chk

    task automatic chk_int(input string nm, input int e, g);
        n_checks++;
        if (g != e) begin
            errors++;
            $display("unexpected %s: expected %0d, seen %0d", nm, e, g);
        end
    endtask : chk_int

    // Flag fields sit in bits 14:8, divisor split round them
    function automatic logic [31:0] cc(input logic [9:0] d,
                                       input logic [6:0] f);
        return (32'(d[9:8]) << DIV_HI_LSB) | (32'(f) << OE_BIT)
            | 32'(d[7:0]);
    endfunction : cc

    // Seven idle clocks after every write, software's spacing duty
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        sel <= 1'b1;
        wr_en <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk_i);
        sel <= 1'b0;
        wr_en <= 1'b0;
        repeat (7) @(posedge clk_i);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input logic e_err);
        @(posedge clk_i);
        sel <= 1'b1;
        wr_en <= 1'b0;
        addr <= a;
        @(posedge clk_i);
        sel <= 1'b0;
        #1;
        chk("read data", e, rdata);
        chk("bus error", 32'(e_err), 32'(err));
    endtask : rd

    task automatic wait_edges(input int n);
        int s;
        int i;
        s = edges;
        for (i = 0; i < 4000 && edges < s + n; i++) @(posedge clk_i);
        if (edges < s + n) begin
            errors++;
            $display("unexpected card clock edges: expected %0d, seen %0d",
                     s + n, edges);
            wrap_up();
        end
    endtask : wait_edges

    // Let the running period finish before watching for silence
    task automatic quiet;
        int s;
        repeat (8) @(posedge clk_i);
        s = edges;
        repeat (30) @(posedge clk_i);
        chk_int("edges while stopped", s, edges);
    endtask : quiet

    task automatic pulse(input logic blk);
        @(posedge clk_i);
        if (blk)
            blk_end <= 1'b1;
        else
            rw_end <= 1'b1;
        @(posedge clk_i);
        blk_end <= 1'b0;
        rw_end <= 1'b0;
    endtask : pulse

    task automatic phase(input logic e_hi, e_lo);
        repeat (3) @(posedge clk_i);
        #25 chk("bypass high phase", 32'(e_hi), 32'(pin));
        #50 chk("bypass low phase", 32'(e_lo), 32'(pin));
    endtask : phase

    initial begin
        {sel, wr_en, bus_act, rw_stop, blk_end, rw_end, tx_f, rx_f} = '0;
        addr = '0;
        wdata = '0;
        errors = 0;
        n_checks = 0;
        rstn_i = 1'b0;
        repeat (10) @(posedge clk_i);
        rstn_i <= 1'b1;
        rd(PWR_OFFSET, PWR_RESET, 1'b0);
        rd(CLK_OFFSET, CLK_RESET, 1'b0);
        rd(8'h08, 32'h0, 1'b1);
        rd(8'h01, 32'h0, 1'b1);
        chk("lane mask", 32'(LANES_ONE), 32'(lanes));
        wr(8'h08, 32'hffff_ffff);
        rd(PWR_OFFSET, 32'h0, 1'b0);
        wr(CLK_OFFSET, cc(10'h3ff, 7'h01));
        quiet();
        wr(PWR_OFFSET, 32'h1);
        quiet();
        wr(PWR_OFFSET, 32'h2);
        quiet();
        chk("power on", 32'h0, 32'(pwr_on));
        wr(PWR_OFFSET, 32'hffff_ffff);
        rd(PWR_OFFSET, 32'(PS_ON), 1'b0);
        chk("power on", 32'h1, 32'(pwr_on));
        foreach (divs[k]) begin
            wr(CLK_OFFSET, cc(divs[k], 7'h01));
            wait_edges(3);
            chk_int("card period", (int'(divs[k]) + 2) * 100, period);
        end
        rd(CLK_OFFSET, cc(10'h0, 7'h01), 1'b0);
        wr(CLK_OFFSET, cc(10'h0, 7'h00));
        quiet();
        wr(CLK_OFFSET, cc(10'h0, 7'h03));
        quiet();
        bus_act <= 1'b1;
        wait_edges(2);
        wr(CLK_OFFSET, cc(10'h0, 7'h41));
        tx_f <= 1'b1;
        @(posedge clk_i);
        #1 chk("flow enable", 32'h1, 32'(hfc));
        chk("tx flow", 32'h1, 32'(tx_fl));
        chk("rx flow", 32'h0, 32'(rx_fl));
        tx_f <= 1'b0;
        rx_f <= 1'b1;
        @(posedge clk_i);
        #1 chk("rx flow", 32'h1, 32'(rx_fl));
        rd(CLK_OFFSET, cc(10'h0, 7'h41), 1'b0);
        quiet();
        wr(CLK_OFFSET, cc(10'h0, 7'h01));
        chk("rx flow", 32'h0, 32'(rx_fl));
        wait_edges(2);
        rx_f <= 1'b0;
        wr(CLK_OFFSET, cc(10'h0, 7'h05));
        phase(1'b1, 1'b0);
        wr(CLK_OFFSET, cc(10'h0, 7'h25));
        phase(1'b0, 1'b1);
        wr(CLK_OFFSET, cc(10'h0, 7'h21));
        wait_edges(3);
        chk_int("card period", 200, period);
        for (int w = 0; w < 4; w++) begin
            wr(CLK_OFFSET, cc(10'h0, 7'h01 | 7'(w << 3)));
            chk("lane width", 32'(w), 32'(width));
            chk("lane mask", 32'(lane_exp[w]), 32'(lanes));
        end
        rw_stop <= 1'b1;
        wait_edges(2);
        pulse(1'b1);
        quiet();
        pulse(1'b0);
        rw_stop <= 1'b0;
        wait_edges(2);
        wr(PWR_OFFSET, 32'h0);
        quiet();
        wrap_up();
    end
endmodule : tb_top
